// ==== olsb_bank.v ====
// Purpose: Open-load status bank for twelve half-bridge outputs over APB
// Assumes: Detection inputs are synchronous to ref_clk
// Notes:   Status reads return snapshot taken in setup phase, then clear it
//
// Contract
// - Detected open load sets flag, stays latched
// - All open-load flags reset to zero
// - Outputs 1-4 register, HS4 bit7 down
// - Pattern 100 01 selects outputs 5-8
// - Pattern 010 01 selects outputs 9-12
// - Separate flag per low and high switch
// - Pattern 000 01 selects outputs 1-4
//
// Register access over APB and the placing of the registers were left to the implementer.
`include "olsb_defs.vh"

module olsb_bank (
    // Clock and reset
    input  wire                               ref_clk,
    input  wire                               reset_n,
    // APB slave
    input  wire                               psel,
    input  wire                               penable,
    input  wire                               pwrite,
    input  wire [7:0]                         paddr,
    input  wire [31:0]                        pwdata,
    input  wire [3:0]                         pstrb,
    output wire                               pready,
    output wire [31:0]                        prdata,
    output wire                               pslverr,
    // Open-load detection, one bit per bridge
    input  wire [`OLSB_NUM_BRIDGES-1:0]       detectLow,
    input  wire [`OLSB_NUM_BRIDGES-1:0]       detectHigh,
    // Status view
    output wire [`OLSB_NUM_BRIDGES*2-1:0]     openLoadFlags,
    output wire                               anyOpenLoad
);

    localparam integer NREG = `OLSB_NUM_REGS;
    localparam integer RW   = `OLSB_REG_W;
    localparam integer NB   = `OLSB_NUM_BRIDGES;
    localparam integer BPR  = `OLSB_BRIDGES_PER_REG;

    // Reset release through two flip-flops
    reg  [1:0] rstSync_ff;
    wire       rstSyncN;

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstSync_ff <= 2'b00;
        end else begin
            rstSync_ff <= {rstSync_ff[0], 1'b1};
        end
    end

    assign rstSyncN = rstSync_ff[1];

    // Byte addresses of the registers
    wire [7:0] addrOut1to4  = {`OLSB_IDX_OUT1_4, 2'b00};
    wire [7:0] addrOut5to8  = {`OLSB_IDX_OUT5_8, 2'b00};
    wire [7:0] addrOut9to12 = {`OLSB_IDX_OUT9_12, 2'b00};
    wire [7:0] addrDetEn    = {`OLSB_IDX_DET_ENABLE, 2'b00};

    // Bus phases
    wire setupPhase  = psel & ~penable;
    wire accessPhase = psel & penable;

    // Address decode
    reg  [NREG-1:0] hitStatus;
    reg             hitDetEn;
    wire            hitAny;

    always @* begin
        hitStatus    = {NREG{1'b0}};
        hitStatus[0] = (paddr == addrOut1to4);
        hitStatus[1] = (paddr == addrOut5to8);
        hitStatus[2] = (paddr == addrOut9to12);
        hitDetEn     = (paddr == addrDetEn);
    end

    assign hitAny = (|hitStatus) | hitDetEn;

    // Read hits, decided in the setup cycle
    wire            rdHitStatus = ~pwrite & (|hitStatus);
    wire            rdHitDetEn  = ~pwrite & hitDetEn;

    // Detection enable register, one bit per switch
    reg  [NB*2-1:0] detEnable_ff;
    reg  [NB*2-1:0] nxt_detEnable;
    wire [31:0]     wrMask;

    assign wrMask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    always @* begin
        nxt_detEnable = detEnable_ff;
        if (accessPhase && pwrite && hitDetEn) begin
            nxt_detEnable = (detEnable_ff & ~wrMask[NB*2-1:0])
                          | (pwdata[NB*2-1:0] & wrMask[NB*2-1:0]);
        end
    end

    always @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            detEnable_ff <= `OLSB_RST_DET_ENABLE;
        end else begin
            detEnable_ff <= nxt_detEnable;
        end
    end

    // Pack detections into status byte order, pair per bridge
    wire [NB*2-1:0] detPacked;

    genvar h;
    generate
        for (h = 0; h < NB; h = h + 1) begin : gPack
            // Low at even bit, high at odd bit of each pair
            assign detPacked[2*h + `OLSB_POS_LOW]  = detectLow[h]
                                                   & detEnable_ff[2*h + `OLSB_POS_LOW];
            assign detPacked[2*h + `OLSB_POS_HIGH] = detectHigh[h]
                                                   & detEnable_ff[2*h + `OLSB_POS_HIGH];
        end
    endgenerate

    // Read snapshot and pending clear
    reg  [31:0]     rdata_ff;
    reg  [31:0]     nxt_rdata;
    reg  [RW-1:0]   snap_ff;
    reg  [RW-1:0]   nxt_snap;
    reg  [NREG-1:0] snapSel_ff;
    reg  [NREG-1:0] nxt_snapSel;
    reg             err_ff;
    reg             nxt_err;
    wire [NB*2-1:0] flagsAll;
    reg  [RW-1:0]   rdStatus;
    integer         k;

    always @* begin
        rdStatus = {RW{1'b0}};
        for (k = 0; k < NREG; k = k + 1) begin
            if (hitStatus[k]) begin
                rdStatus = flagsAll[k*RW +: RW];
            end
        end
    end

    always @* begin
        nxt_rdata   = rdata_ff;
        nxt_snap    = snap_ff;
        nxt_snapSel = snapSel_ff;
        nxt_err     = err_ff;
        if (setupPhase) begin
            nxt_err     = ~hitAny;
            nxt_snap    = {RW{1'b0}};
            nxt_snapSel = {NREG{1'b0}};
            nxt_rdata   = `OLSB_RST_RDATA;
            if (rdHitStatus) begin
                // Capture latched flags for return
                nxt_rdata   = {{(32-RW){1'b0}}, rdStatus};
                nxt_snap    = rdStatus;
                nxt_snapSel = hitStatus;
            end else if (rdHitDetEn) begin
                nxt_rdata = {{(32-NB*2){1'b0}}, detEnable_ff};
            end
        end else if (accessPhase) begin
            nxt_snapSel = {NREG{1'b0}};
        end
    end

    always @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            rdata_ff   <= `OLSB_RST_RDATA;
            snap_ff    <= `OLSB_RST_STATUS;
            snapSel_ff <= {NREG{1'b0}};
            err_ff     <= 1'b0;
        end else begin
            rdata_ff   <= nxt_rdata;
            snap_ff    <= nxt_snap;
            snapSel_ff <= nxt_snapSel;
            err_ff     <= nxt_err;
        end
    end

    // Status registers, one instance each
    genvar r;
    generate
        for (r = 0; r < NREG; r = r + 1) begin : gReg
            wire [RW-1:0] clrMask;

            // Clear only the returned bits at access completion
            assign clrMask = (accessPhase && snapSel_ff[r]) ? snap_ff : {RW{1'b0}};

            olsb_flag_reg uFlags (
                .ref_clk  (ref_clk),
                .rstSyncN (rstSyncN),
                .setMask  (detPacked[r*BPR*2 +: RW]),
                .clrMask  (clrMask),
                .flags    (flagsAll[r*RW +: RW])
            );
        end
    endgenerate

    // Bus answers
    assign pready  = accessPhase;
    assign prdata  = rdata_ff;
    assign pslverr = accessPhase & err_ff;

    // Summary flag, one cycle behind the flags
    reg             anyOpen_ff;
    wire            nxt_anyOpen = |flagsAll;

    always @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            anyOpen_ff <= `OLSB_RST_ANY;
        end else begin
            anyOpen_ff <= nxt_anyOpen;
        end
    end

    // Status view
    assign openLoadFlags = flagsAll;
    assign anyOpenLoad   = anyOpen_ff;

endmodule

// ==== olsb_defs.vh ====
// Purpose: Constants for the open-load status bank
// Assumes: APB byte address is four times the register index
// Notes:   Status indices equal the 5-bit address-byte patterns
`ifndef OLSB_DEFS_VH
`define OLSB_DEFS_VH

// Register indices
`define OLSB_IDX_OUT1_4      6'h01
`define OLSB_IDX_OUT5_8      6'h11
`define OLSB_IDX_OUT9_12     6'h09
`define OLSB_IDX_DET_ENABLE  6'h20

// Widths
`define OLSB_REG_W           8
`define OLSB_NUM_REGS        3
`define OLSB_NUM_BRIDGES     12
`define OLSB_BRIDGES_PER_REG 4

// Field positions inside a status byte, per bridge pair
`define OLSB_POS_LOW         0
`define OLSB_POS_HIGH        1

// Reset values
`define OLSB_RST_STATUS      8'h00
`define OLSB_RST_DET_ENABLE  24'hFFFFFF
`define OLSB_RST_RDATA       32'h00000000
`define OLSB_RST_ANY         1'b0

`endif

// ==== olsb_flag_reg.v ====
// Purpose: One 8-bit latched flag register with set and clear masks
// Assumes: Set and clear arrive as one-cycle masks on ref_clk
// Notes:   Set wins over clear in the same cycle
`include "olsb_defs.vh"

module olsb_flag_reg (
    // Clock and reset
    input  wire                     ref_clk,
    input  wire                     rstSyncN,
    // Flag control
    input  wire [`OLSB_REG_W-1:0]   setMask,
    input  wire [`OLSB_REG_W-1:0]   clrMask,
    // Flag state
    output wire [`OLSB_REG_W-1:0]   flags
);

    reg  [`OLSB_REG_W-1:0] flag_ff;
    wire [`OLSB_REG_W-1:0] nxt_flag;

    genvar b;
    generate
        for (b = 0; b < `OLSB_REG_W; b = b + 1) begin : gBit
            // Latched: holds until cleared, new detection wins
            assign nxt_flag[b] = setMask[b] | (flag_ff[b] & ~clrMask[b]);
        end
    endgenerate

    always @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            flag_ff <= `OLSB_RST_STATUS;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    assign flags = flag_ff;

endmodule

// ==== olsb_host.sv ====
// Purpose: APB master standing in for the host controller
// Assumes: Slave answers when pready is high
// Notes:   Signals change only right after a rising edge
module olsb_host (
    // Clock
    input  logic        ref_clk,
    // APB answer
    input  logic        pready,
    input  logic [31:0] prdata,
    input  logic        pslverr,
    // APB request
    output logic        psel = 1'b0,
    output logic        penable = 1'b0,
    output logic        pwrite = 1'b0,
    output logic [7:0]  paddr = 8'h00,
    output logic [31:0] pwdata = 32'h0,
    output logic [3:0]  pstrb = 4'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= wr ? 4'hF : 4'h0;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// ==== olsb_chk.sv ====
// Purpose: Port assertions for the status bank
// Assumes: Bridge 4 detection stays enabled
// Notes:   Bound to every bank instance
module olsb_chk (
    // Clock and reset
    input logic        ref_clk,
    input logic        reset_n,
    // APB
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [7:0]  paddr,
    input logic [31:0] prdata,
    // Detection and status
    input logic [11:0] detectLow,
    input logic [11:0] detectHigh,
    input logic [23:0] openLoadFlags
);
    timeunit 1ns;
    timeprecision 1ps;
    // Mirror of the bank's reset release
    logic [1:0] rstShadow_ff;
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) rstShadow_ff <= 2'b00;
        else rstShadow_ff <= {rstShadow_ff[0], 1'b1};
    end
    wire        rstDone = rstShadow_ff[1];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstDone);
    wire       rdSetup = psel & ~penable & ~pwrite;
    wire       rdAcc   = psel & penable & ~pwrite;
    wire [7:0] det14   = {detectHigh[3:0], detectLow[3:0]};
    property p_set; detectHigh[3] |=> openLoadFlags[7]; endproperty
    property p_hold;
        !rdAcc |=> (openLoadFlags & $past(openLoadFlags)) == $past(openLoadFlags);
    endproperty
    property p_rst;
        disable iff (!reset_n) $rose(reset_n) |-> openLoadFlags == 24'h0 && prdata == 32'h0;
    endproperty
    property p_rd14;
        rdSetup && paddr == 8'h04 |=> prdata == {24'h0, $past(openLoadFlags[7:0])};
    endproperty
    property p_rd58;
        rdSetup && paddr == 8'h44 |=> prdata == {24'h0, $past(openLoadFlags[15:8])};
    endproperty
    property p_rd912;
        rdSetup && paddr == 8'h24 |=> prdata == {24'h0, $past(openLoadFlags[23:16])};
    endproperty
    property p_clr;
        rdSetup && paddr == 8'h04 && det14 == 8'h0 ##1 det14 == 8'h0
            |=> openLoadFlags[7:0] == 8'h0;
    endproperty
    property p_sep;
        detectLow[3] && !detectHigh[3] && !openLoadFlags[7] |=> openLoadFlags[7:6] == 2'b01;
    endproperty
    a_set: assert property (p_set) else $error("flag not set");
    a_hold: assert property (p_hold) else $error("flag dropped");
    a_rst: assert property (p_rst) else $error("bad reset value");
    a_rd14: assert property (p_rd14) else $error("bad read 1-4");
    a_rd58: assert property (p_rd58) else $error("bad read 5-8");
    a_rd912: assert property (p_rd912) else $error("bad read 9-12");
    a_clr: assert property (p_clr) else $error("flags not cleared");
    a_sep: assert property (p_sep) else $error("switch flags linked");
    cover property (rdAcc && paddr == 8'h04 && prdata != 32'h0);
    cover property (rdAcc && paddr == 8'h44 && prdata != 32'h0);
    cover property (rdAcc && paddr == 8'h24 && prdata != 32'h0);
endmodule
bind olsb_bank olsb_chk olsb_chk_i (
    .ref_clk       (ref_clk),
    .reset_n       (reset_n),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .prdata        (prdata),
    .detectLow     (detectLow),
    .detectHigh    (detectHigh),
    .openLoadFlags (openLoadFlags)
);

// ==== olsb_tb.sv ====
// Purpose: Self-checking bench for the status bank
// Assumes: APB master lives in olsb_host
// Notes:   Every switch is set, read and cleared
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [11:0] detectLow = 12'h0;
    logic [11:0] detectHigh = 12'h0;
    wire         psel, penable, pwrite, pready, pslverr, anyOpenLoad;
    wire [7:0]   paddr;
    wire [31:0]  pwdata, prdata;
    wire [3:0]   pstrb;
    wire [23:0]  openLoadFlags;
    int          num_errors = 0;
    int          tests_run = 0;
    logic [7:0]  regAddr [3] = '{8'h04, 8'h44, 8'h24};
    olsb_bank olsb_bank_i (
        .ref_clk       (ref_clk),
        .reset_n       (reset_n),
        .psel          (psel),
        .penable       (penable),
        .pwrite        (pwrite),
        .paddr         (paddr),
        .pwdata        (pwdata),
        .pstrb         (pstrb),
        .pready        (pready),
        .prdata        (prdata),
        .pslverr       (pslverr),
        .detectLow     (detectLow),
        .detectHigh    (detectHigh),
        .openLoadFlags (openLoadFlags),
        .anyOpenLoad   (anyOpenLoad)
    );
    olsb_host olsb_host_i (
        .ref_clk (ref_clk),
        .pready  (pready),
        .prdata  (prdata),
        .pslverr (pslverr),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pstrb   (pstrb)
    );
    initial forever #5 ref_clk = ~ref_clk;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic errExp);
        logic [31:0] d;
        logic        e;
        olsb_host_i.xfer(1'b0, a, 32'h0, d, e);
        chk("prdata", d, exp);
        chk("pslverr", {31'h0, e}, {31'h0, errExp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] d;
        logic        e;
        olsb_host_i.xfer(1'b1, a, v, d, e);
    endtask
    task automatic pulse(input int h, input logic s);
        @(posedge ref_clk);
        if (s) detectHigh[h] <= 1'b1;
        else detectLow[h] <= 1'b1;
        @(posedge ref_clk);
        detectLow <= 12'h0;
        detectHigh <= 12'h0;
    endtask
    task conclude;
        if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        for (int r = 0; r < 3; r++) rd(regAddr[r], 32'h0, 1'b0);
        chk("anyOpenLoad", {31'h0, anyOpenLoad}, 32'h0);
        rd(8'h80, 32'h00FFFFFF, 1'b0);
        for (int h = 0; h < 12; h++) begin
            for (int s = 0; s < 2; s++) begin
                pulse(h, s[0]);
                repeat (2) @(posedge ref_clk);
                chk("anyOpenLoad", {31'h0, anyOpenLoad}, 32'h1);
                rd(regAddr[h / 4], 32'h1 << (2 * (h % 4) + s), 1'b0);
                rd(regAddr[h / 4], 32'h0, 1'b0);
                chk("anyOpenLoad", {31'h0, anyOpenLoad}, 32'h0);
            end
        end
        pulse(3, 1'b1);
        wr(8'h04, 32'h0);
        rd(8'h08, 32'h0, 1'b1);
        rd(8'h04, 32'h80, 1'b0);
        rd(8'h04, 32'h0, 1'b0);
        detectHigh <= 12'h008;
        repeat (2) @(posedge ref_clk);
        rd(8'h04, 32'h80, 1'b0);
        detectHigh <= 12'h000;
        rd(8'h04, 32'h80, 1'b0);
        rd(8'h04, 32'h0, 1'b0);
        wr(8'h80, 32'h00FFFFFE);
        rd(8'h80, 32'h00FFFFFE, 1'b0);
        pulse(0, 1'b0);
        rd(8'h04, 32'h0, 1'b0);
        pulse(5, 1'b1);
        @(posedge ref_clk);
        chk("openLoadFlags", {8'h0, openLoadFlags}, 32'h800);
        reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk("openLoadFlags", {8'h0, openLoadFlags}, 32'h0);
        chk("anyOpenLoad", {31'h0, anyOpenLoad}, 32'h0);
        rd(8'h44, 32'h0, 1'b0);
        rd(8'h80, 32'h00FFFFFF, 1'b0);
        wr(8'h80, 32'h00FFFFFF);
        conclude();
    end
    initial begin
        #100us;
        num_errors++;
        conclude();
    end
endmodule
